// ===== prs_sequencer.sv
`timescale 1ns/1ps
module prs_sequencer
   import prs_pkg::*;
#(
   // Hiccup retry period in cycles; shorten for simulation.
   parameter int unsigned RETRY_CYC = RETRY_CYC_DEF
) (
   // Clock and asynchronous active-low reset.
   input wire logic mclk,
   input wire logic rst_n,
   // Pins, comparators and regulator status.
   input wire prs_pin_s pins,
   // Configuration from the register block.
   input wire prs_cfg_s cfg,
   // Rail controls.
   output logic [5:0] rail_enable,
   output logic [5:0] rail_low_power,
   output logic [5:0] rail_switch_open,
   output logic [5:0] rail_discharge,
   output logic [11:0] rail_soft_start,
   // Buck B and C voltage selections.
   output logic [7:0] buck_b_voltage,
   output logic [7:0] buck_c_voltage,
   // System status.
   output logic power_good_reset_out,
   output prs_state_e sequencer_state
);

   // Registered state and its next value.
   prs_state_s r_q;
   prs_state_s r_d;
   // Synchronised pin view; only the second stage is ever read.
   prs_pin_s p;
   // Sleep request per source and combined.
   logic sleep_a;
   logic sleep_b;
   logic sleep_any;
   // Rails that some active sleep source wants off.
   logic [5:0] off_in_sleep;
   // Rails allowed to run at all under present settings.
   logic [5:0] elig;
   // Tick strobe of the shared time base.
   logic tick;
   // Pair input rising edge.
   logic pair_rise;
   // Selected DVS switch bit.
   logic dvs_sel;
   // Sequence completion flag.
   logic done;
   // Rails still to drop during sleep entry.
   logic [5:0] pend_off;

   // Next-state logic: synchroniser, time base, protection and sequencing.
   always_comb begin
      r_d = r_q;
      p = r_q.s2;
      // Two-stage synchroniser for every asynchronous input.
      r_d.s1 = pins;
      r_d.s2 = r_q.s1;
      r_d.pair_prev = p.buck_pair_enable_input;
      pair_rise = p.buck_pair_enable_input & ~r_q.pair_prev;
      // A low pin or a software bit requests sleep from that source.
      sleep_a = ~p.sleep_request_a | cfg.sleep_software_enable[0];
      sleep_b = ~p.sleep_request_b | cfg.sleep_software_enable[1];
      sleep_any = sleep_a | sleep_b;
      // Off wins over keep when both sources are active.
      off_in_sleep = (sleep_a ? ~cfg.keep_in_sleep_a : 6'h00)
                   | (sleep_b ? ~cfg.keep_in_sleep_b : 6'h00);
      // Source B decides the voltage whenever it is active.
      dvs_sel = sleep_b ? cfg.sleep_voltage_switch_enable[1]
                        : cfg.sleep_voltage_switch_enable[0];
      // Slot code zero disables a rail; the pair also needs its input.
      for (int unsigned i = 0; i < NRAIL; i++) begin
         elig[i] = (cfg.rail_slot[i] != SLOT_OFF)
                 && (i > PAIR_LAST || p.buck_pair_enable_input);
      end
      done = &(~elig | (r_q.en & p.rail_power_ok));
      pend_off = r_q.en & off_in_sleep;
      // One prescaler feeds every slot, shutdown and resume delay, so steps stay exact.
      tick = (r_q.pre == 12'(TICK_CYC - 1));
      r_d.pre = tick ? 12'h000 : r_q.pre + 12'h001;
      r_d.tk = (tick && r_q.tk != 8'hff) ? r_q.tk + 8'h01 : r_q.tk;

      if (!p.above_undervoltage_lockout) begin
         // Lockout overrides everything and drops all rails together.
         r_d.st = ST_OFF;
         r_d.en = 6'h00;
         r_d.hiz = 6'h00;
         r_d.pgood = 1'b0;
      end else if (r_q.st == ST_OFF) begin
         // Waking from lockout catches the strap once, after synchronising.
         r_d.st = ST_STANDBY;
         r_d.strap = p.sequence_strap_pin;
         r_d.cyc = 12'h000;
      end else if (p.power_disable_input) begin
         // Disable drops every rail at once, ignoring shutdown delays.
         r_d.st = ST_STANDBY;
         r_d.en = 6'h00;
         r_d.hiz = 6'h00;
         r_d.pgood = 1'b0;
         r_d.cyc = 12'h000;
      end else if (p.over_temp) begin
         // Hot die: rails off, controller keeps running.
         r_d.st = ST_THERMAL;
         r_d.hiz = 6'h00;
         r_d.en = 6'h00;
         r_d.pgood = 1'b0;
      end else if ((|p.rail_fault) && (r_q.st inside {ST_POWERUP, ST_NORMAL,
                                        ST_SLEEP_ENTRY, ST_SLEEP, ST_WAKE})) begin
         // Faulted rail opens both switches; the others discharge.
         r_d.st = ST_RECOVER;
         r_d.hiz = p.rail_fault;
         r_d.en = 6'h00;
         r_d.pgood = 1'b0;
         r_d.ret = 24'h000000;
      end else begin
         case (r_q.st)
            ST_STANDBY: begin
               // Start only above the monitor level and with outputs bled down.
               if (p.above_monitor && (cfg.residual_guard_mask
                   || !(|p.residual_voltage_guard))) begin
                  r_d.cyc = r_q.cyc + 12'h001;
                  // Deglitch and startup delay set the slot zero point.
                  if (r_q.cyc == 12'(QUAL_CYC - 1)) begin
                     r_d.st = ST_POWERUP;
                     r_d.pre = 12'h000;
                     r_d.tk = 8'h00;
                  end
               end else begin
                  r_d.cyc = 12'h000;
               end
            end
            ST_POWERUP: begin
               // Each rail rises when its slot, extra and strap delay expire.
               for (int unsigned i = 0; i < NRAIL; i++) begin
                  if (elig[i] && !r_q.en[i]
                      && r_q.tk >= prs_up_ticks(cfg, r_q.strap, i)) begin
                     r_d.en[i] = 1'b1;
                     r_d.ss[i] = cfg.rail_soft_start_select[i];
                  end
               end
               // All wanted rails up and good: declare normal.
               if (done) begin
                  r_d.st = ST_NORMAL;
                  r_d.pgood = 1'b1;
               end
            end
            ST_NORMAL: begin
               if (sleep_any) begin
                  // Sleep outranks the pair input.
                  r_d.st = ST_SLEEP_ENTRY;
                  r_d.pre = 12'h000;
                  r_d.tk = 8'h00;
               end else if (pair_rise) begin
                  // Pair raised late follows the wake-up timing.
                  r_d.st = ST_WAKE;
                  r_d.cyc = 12'h000;
                  r_d.pre = 12'h000;
                  r_d.tk = 8'h00;
               end else if (!p.buck_pair_enable_input) begin
                  // Pair input low keeps the pair off.
                  r_d.en[PAIR_LAST:0] = 2'b00;
               end
            end
            ST_SLEEP_ENTRY: begin
               // Shutdown delays act here only; zero-delay rails drop together.
               for (int unsigned i = 0; i < NRAIL; i++) begin
                  if (off_in_sleep[i]
                      && r_q.tk >= 8'(cfg.rail_sleep_shutdown_delay[i])) begin
                     r_d.en[i] = 1'b0;
                  end
               end
               if (!sleep_any) begin
                  r_d.st = ST_WAKE;
                  r_d.cyc = 12'h000;
                  r_d.pre = 12'h000;
                  r_d.tk = 8'h00;
               end else if (!(|pend_off)) begin
                  r_d.st = ST_SLEEP;
               end
            end
            ST_SLEEP: begin
               // Removing every sleep request starts the wake-up sequence.
               if (!sleep_any) begin
                  r_d.st = ST_WAKE;
                  r_d.cyc = 12'h000;
                  r_d.pre = 12'h000;
                  r_d.tk = 8'h00;
               end
            end
            ST_WAKE: begin
               if (sleep_any) begin
                  // A new request aborts the wake and re-enters sleep.
                  r_d.st = ST_SLEEP_ENTRY;
                  r_d.pre = 12'h000;
                  r_d.tk = 8'h00;
               end else if (r_q.cyc < 12'(EXIT_CYC)) begin
                  // Exit time: hold the time base at zero.
                  r_d.cyc = r_q.cyc + 12'h001;
                  r_d.pre = 12'h000;
                  r_d.tk = 8'h00;
               end else begin
                  // Off rails restart on resume plus extra delay.
                  for (int unsigned i = 0; i < NRAIL; i++) begin
                     if (elig[i] && !r_q.en[i]
                         && r_q.tk >= prs_resume_ticks(cfg, i)) begin
                        r_d.en[i] = 1'b1;
                        r_d.ss[i] = cfg.rail_soft_start_select[i];
                     end
                  end
                  if (done) begin
                     r_d.st = ST_NORMAL;
                  end
               end
            end
            ST_THERMAL: begin
               // Cooled below the recovery point: sequence again.
               if (p.below_recover_temp) begin
                  r_d.st = ST_STANDBY;
                  r_d.cyc = 12'h000;
               end
            end
            ST_RECOVER: begin
               // Hiccup: wait one period, retry only if no rail is faulted.
               r_d.hiz = r_q.hiz | p.rail_fault;
               r_d.ret = r_q.ret + 24'h000001;
               if (r_q.ret == 24'(RETRY_CYC - 1)) begin
                  r_d.ret = 24'h000000;
                  if (!(|p.rail_fault)) begin
                     r_d.st = ST_STANDBY;
                     r_d.hiz = 6'h00;
                     r_d.cyc = 12'h000;
                  end
               end
            end
            default: begin
               // Unknown code: fall back to a safe restart.
               r_d.st = ST_STANDBY;
               r_d.en = 6'h00;
               r_d.pgood = 1'b0;
               r_d.cyc = 12'h000;
            end
         endcase
      end

      // Sleep voltages apply only while settled in sleep.
      r_d.vb = (r_d.st == ST_SLEEP && dvs_sel) ? cfg.buck_b_sleep_voltage
                                               : cfg.buck_b_normal_voltage;
      r_d.vc = (r_d.st == ST_SLEEP && dvs_sel) ? cfg.buck_c_sleep_voltage
                                               : cfg.buck_c_normal_voltage;
      // Rails alive in sleep run in low-power mode.
      r_d.lp = (r_d.st == ST_SLEEP) ? r_d.en : 6'h00;
      // Disabled rails are bled down unless their switches are held open.
      r_d.dis = ~r_d.en & ~r_d.hiz;
   end

   // State register; reset loads constants only.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         r_q <= PRS_STATE_RESET;
      end else begin
         r_q <= r_d;
      end
   end

   // Outputs straight from the state register.
   assign rail_enable = r_q.en;
   assign rail_low_power = r_q.lp;
   assign rail_switch_open = r_q.hiz;
   assign rail_discharge = r_q.dis;
   assign rail_soft_start = r_q.ss;
   assign buck_b_voltage = r_q.vb;
   assign buck_c_voltage = r_q.vc;
   assign power_good_reset_out = r_q.pgood;
   assign sequencer_state = r_q.st;

endmodule

// ===== prs_pkg.sv
package prs_pkg;
   // Clock rate in kHz and time figures in their own units.
   localparam int unsigned CLK_KHZ = 10000;
   localparam int unsigned TICK_US = 250;
   localparam int unsigned DEGLITCH_US = 10;
   localparam int unsigned STARTUP_US = 380;
   localparam int unsigned EXIT_NS = 1000;
   localparam int unsigned RETRY_MS = 100;
   // Derived cycle counts; least times round up, the exit time rounds down.
   localparam int unsigned TICK_CYC = (TICK_US * CLK_KHZ + 999) / 1000;
   localparam int unsigned QUAL_CYC = ((DEGLITCH_US + STARTUP_US) * CLK_KHZ + 999) / 1000;
   localparam int unsigned EXIT_CYC = EXIT_NS * CLK_KHZ / 1000000;
   localparam int unsigned RETRY_CYC_DEF = RETRY_MS * CLK_KHZ;
   // Rail count; rails 0 and 1 form the gated buck pair, 1 and 2 carry DVS.
   localparam int unsigned NRAIL = 6;
   localparam int unsigned PAIR_LAST = 1;
   localparam int unsigned RAIL_BUCK_B = 1;
   localparam int unsigned RAIL_BUCK_C = 2;
   // Slot code that keeps a rail off in every sequence.
   localparam logic [4:0] SLOT_OFF = 5'h00;
   // Strap level codes from the three-level pin sense.
   localparam logic [1:0] STRAP_HIZ = 2'h0;
   localparam logic [1:0] STRAP_LOW = 2'h1;
   localparam logic [1:0] STRAP_HIGH = 2'h2;
   // Extra strap delay in ticks, indexed [strap][rail]; rails 0 and 1 get none.
   localparam logic [2:0][5:0][3:0] STRAP_DLY = {24'h123400, 24'h432100, 24'h000000};
   // Resume delay in ticks: 0, 250, 500, 750, 1000, 2000, 4000, 8000 us.
   localparam logic [7:0][5:0] RESUME_TICKS = {6'h20, 6'h10, 6'h08, 6'h04,
                                               6'h03, 6'h02, 6'h01, 6'h00};

   // Sequencer states.
   typedef enum logic [3:0] {
      ST_OFF = 4'b0000,
      ST_STANDBY = 4'b0001,
      ST_POWERUP = 4'b0010,
      ST_NORMAL = 4'b0011,
      ST_SLEEP_ENTRY = 4'b0100,
      ST_SLEEP = 4'b0101,
      ST_WAKE = 4'b0110,
      ST_THERMAL = 4'b0111,
      ST_RECOVER = 4'b1000
   } prs_state_e;

   // Pins and comparator results, all asynchronous to mclk.
   typedef struct packed {
      logic above_undervoltage_lockout;
      logic above_monitor;
      logic power_disable_input;
      logic sleep_request_a;
      logic sleep_request_b;
      logic buck_pair_enable_input;
      logic over_temp;
      logic below_recover_temp;
      logic [1:0] sequence_strap_pin;
      logic [5:0] rail_fault;
      logic [5:0] residual_voltage_guard;
      logic [5:0] rail_power_ok;
   } prs_pin_s;

   // Configuration held by the register block, on mclk.
   typedef struct packed {
      logic [5:0][4:0] rail_slot;
      logic [5:0][3:0] rail_extra_enable_delay;
      logic [5:0][2:0] rail_resume_delay;
      logic [5:0][3:0] rail_sleep_shutdown_delay;
      logic [5:0][1:0] rail_soft_start_select;
      logic [5:0] keep_in_sleep_a;
      logic [5:0] keep_in_sleep_b;
      logic [1:0] sleep_voltage_switch_enable;
      logic [1:0] sleep_software_enable;
      logic residual_guard_mask;
      logic [7:0] buck_b_normal_voltage;
      logic [7:0] buck_b_sleep_voltage;
      logic [7:0] buck_c_normal_voltage;
      logic [7:0] buck_c_sleep_voltage;
   } prs_cfg_s;

   // Whole state of the sequencer.
   typedef struct packed {
      prs_state_e st;
      prs_pin_s s1;
      prs_pin_s s2;
      logic pair_prev;
      logic [1:0] strap;
      logic [11:0] pre;
      logic [11:0] cyc;
      logic [7:0] tk;
      logic [23:0] ret;
      logic [5:0] en;
      logic [5:0] hiz;
      logic [5:0] lp;
      logic [5:0] dis;
      logic [5:0][1:0] ss;
      logic pgood;
      logic [7:0] vb;
      logic [7:0] vc;
   } prs_state_s;

   localparam prs_state_s PRS_STATE_RESET = '0;

   // Power-up delay of a rail in ticks: slot, extra delay and strap delay.
   function automatic logic [7:0] prs_up_ticks(input prs_cfg_s c, input logic [1:0] s,
                                               input int unsigned i);
      logic [1:0] k;
      k = (s == STRAP_LOW || s == STRAP_HIGH) ? s : STRAP_HIZ;
      return 8'(c.rail_slot[i]) - 8'h01 + 8'(c.rail_extra_enable_delay[i])
             + 8'(STRAP_DLY[k][i]);
   endfunction

   // Wake-up delay of a rail in ticks: table entry plus extra delay.
   function automatic logic [7:0] prs_resume_ticks(input prs_cfg_s c, input int unsigned i);
      return 8'(RESUME_TICKS[c.rail_resume_delay[i]])
             + 8'(c.rail_extra_enable_delay[i]);
   endfunction
endpackage

// ===== prs_rail_model.sv
`timescale 1ns/1ps
// Behavioural regulators: output rises a few cycles after enable, charge bleeds only on discharge.
module prs_rail_model
   import prs_pkg::*;
#(
   parameter int unsigned RISE_CYC = 6,
   parameter int unsigned DECAY_CYC = 40
) (
   // Clock.
   input wire logic mclk,
   // Rail controls from the sequencer.
   input wire logic [5:0] rail_enable,
   input wire logic [5:0] rail_discharge,
   // Commands from the bench.
   input wire logic [5:0] precharge,
   input wire logic [5:0] fault_cmd,
   // Regulator status.
   output logic [5:0] rail_power_ok,
   output logic [5:0] rail_fault,
   output logic [5:0] residual_high
);
   // Rise progress and remaining charge per rail.
   int unsigned up_q [6];
   int unsigned dn_q [6];
   // A rail left floating keeps its charge, so an open switch blocks a guarded restart.
   always_ff @(posedge mclk) begin
      for (int i = 0; i < 6; i++) begin
         up_q[i] <= rail_enable[i] ? ((up_q[i] < RISE_CYC) ? up_q[i] + 1 : up_q[i]) : 0;
         dn_q[i] <= (rail_enable[i] || precharge[i]) ? DECAY_CYC :
                    (rail_discharge[i] && dn_q[i] != 0) ? dn_q[i] - 1 : dn_q[i];
      end
   end
   // Status follows the analog state; a faulted rail never reports good.
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         rail_power_ok[i] = up_q[i] >= RISE_CYC && !fault_cmd[i];
         residual_high[i] = dn_q[i] != 0;
      end
      rail_fault = fault_cmd;
   end
endmodule

// ===== prs_sequencer_asserts.sv
`timescale 1ns/1ps
// Checks the sequencer outputs against its inputs over time.
module prs_sequencer_asserts
   import prs_pkg::*;
#(
   parameter int unsigned RETRY_CYC = RETRY_CYC_DEF
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst_n,
   // Inputs of the sequencer.
   input wire prs_pin_s pins,
   input wire prs_cfg_s cfg,
   // Outputs of the sequencer.
   input wire logic [5:0] rail_enable,
   input wire logic [5:0] rail_low_power,
   input wire logic [5:0] rail_switch_open,
   input wire logic [5:0] rail_discharge,
   input wire logic [11:0] rail_soft_start,
   input wire logic [7:0] buck_b_voltage,
   input wire logic [7:0] buck_c_voltage,
   input wire logic power_good_reset_out,
   input wire prs_state_e sequencer_state
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Cycles spent in standby and in recovery.
   int unsigned stby_q;
   int unsigned rec_q;
   // Rails whose slot code keeps them off.
   logic [5:0] zslot;
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         zslot[i] = cfg.rail_slot[i] == SLOT_OFF;
      end
   end
   // Counters restart on leaving the state, so a shortened wait is caught.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         stby_q <= 0;
         rec_q <= 0;
      end else begin
         stby_q <= (sequencer_state == ST_STANDBY) ? stby_q + 1 : 0;
         rec_q <= (sequencer_state == ST_RECOVER) ? rec_q + 1 : 0;
      end
   end
   slot_off_a: assert property ((rail_enable & zslot) == '0)
      else $error("rail with slot code zero enabled");
   low_power_a: assert property (rail_low_power ==
      ((sequencer_state == ST_SLEEP) ? rail_enable : '0))
      else $error("low power does not match rails alive in sleep");
   discharge_rest_a: assert property (sequencer_state != ST_OFF |->
      rail_discharge == (~rail_enable & ~rail_switch_open))
      else $error("discharge not on every idle closed rail");
   lockout_off_a: assert property (!pins.above_undervoltage_lockout [*4] |->
      sequencer_state == ST_OFF && rail_enable == '0)
      else $error("lockout did not force the off state");
   disable_drop_a: assert property (pins.power_disable_input [*4] |->
      rail_enable == '0 && !power_good_reset_out)
      else $error("disable did not drop all rails");
   thermal_off_a: assert property (pins.over_temp [*4] |->
      rail_enable == '0 && !power_good_reset_out)
      else $error("over temperature left a rail on");
   pgood_rise_a: assert property ($rose(power_good_reset_out) |->
      sequencer_state == ST_NORMAL)
      else $error("power good rose outside normal");
   sleep_volt_a: assert property (!pins.sleep_request_b [*4] ##1
      sequencer_state == ST_SLEEP && $past(sequencer_state) == ST_SLEEP |->
      buck_b_voltage == (cfg.sleep_voltage_switch_enable[1] ?
      cfg.buck_b_sleep_voltage : cfg.buck_b_normal_voltage))
      else $error("sleep voltage not chosen by source b");
   normal_volt_a: assert property (sequencer_state == ST_NORMAL &&
      $past(sequencer_state) == ST_NORMAL |-> buck_c_voltage == cfg.buck_c_normal_voltage)
      else $error("normal voltage not held");
   retry_hold_a: assert property (sequencer_state == ST_RECOVER && rec_q + 2 < RETRY_CYC
      |=> sequencer_state == ST_RECOVER)
      else $error("retry before period elapsed");
   qual_time_a: assert property ($rose(sequencer_state == ST_POWERUP) |->
      stby_q + 1 >= QUAL_CYC)
      else $error("power-up started before qualification time");
   cover property (sequencer_state == ST_SLEEP);
   cover property (sequencer_state == ST_RECOVER);
   cover property (sequencer_state == ST_THERMAL);
endmodule
bind prs_sequencer prs_sequencer_asserts #(.RETRY_CYC(RETRY_CYC)) u_prs_chk (.mclk(mclk),
   .rst_n(rst_n), .pins(pins), .cfg(cfg), .rail_enable(rail_enable),
   .rail_low_power(rail_low_power), .rail_switch_open(rail_switch_open),
   .rail_discharge(rail_discharge), .rail_soft_start(rail_soft_start),
   .buck_b_voltage(buck_b_voltage), .buck_c_voltage(buck_c_voltage),
   .power_good_reset_out(power_good_reset_out), .sequencer_state(sequencer_state));

// ===== prs_sequencer_tb.sv
`timescale 1ns/1ps
// Walks the sequencer through power-up, sleep, pair control, faults and shutdown.
module prs_sequencer_tb
   import prs_pkg::*;
();
   localparam int unsigned RETRY = 50;
   // One expected result: which output, and its value.
   typedef struct packed {
      logic [2:0] sel;
      logic [31:0] exp;
   } prs_note_s;
   logic mclk, rst_n;
   prs_pin_s pin_drv, pin_w;
   prs_cfg_s cfg;
   logic [5:0] precharge, fault_cmd, pok_w, fault_w, resid_w;
   logic [5:0] rail_enable, rail_low_power, rail_switch_open, rail_discharge;
   logic [11:0] rail_soft_start;
   logic [7:0] buck_b_voltage, buck_c_voltage;
   logic power_good_reset_out;
   prs_state_e sequencer_state;
   prs_note_s exp_q[$];
   int fails = 0;
   int n_compared = 0;
   int cycles = 0;
   prs_sequencer #(.RETRY_CYC(RETRY)) dut (.mclk(mclk), .rst_n(rst_n), .pins(pin_w), .cfg(cfg),
      .rail_enable(rail_enable), .rail_low_power(rail_low_power),
      .rail_switch_open(rail_switch_open), .rail_discharge(rail_discharge),
      .rail_soft_start(rail_soft_start), .buck_b_voltage(buck_b_voltage),
      .buck_c_voltage(buck_c_voltage), .power_good_reset_out(power_good_reset_out),
      .sequencer_state(sequencer_state));
   prs_rail_model u_rails (.mclk(mclk), .rail_enable(rail_enable), .rail_discharge(rail_discharge),
      .precharge(precharge), .fault_cmd(fault_cmd), .rail_power_ok(pok_w), .rail_fault(fault_w),
      .residual_high(resid_w));
   // Regulator status comes from the model, everything else from the bench.
   always_comb begin
      pin_w = pin_drv;
      pin_w.rail_power_ok = pok_w;
      pin_w.rail_fault = fault_w;
      pin_w.residual_voltage_guard = resid_w;
   end
   initial begin
      mclk = 0;
      forever #50 mclk = ~mclk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] obs(input logic [2:0] sel);
      case (sel)
         3'h0: obs = 32'(rail_enable);
         3'h1: obs = 32'(sequencer_state);
         3'h2: obs = 32'(power_good_reset_out);
         3'h3: obs = 32'(buck_b_voltage);
         3'h4: obs = 32'(buck_c_voltage);
         3'h5: obs = 32'(rail_low_power);
         3'h6: obs = 32'(rail_discharge);
         default: obs = 32'({rail_soft_start, rail_switch_open});
      endcase
   endfunction
   // Results are read mid-cycle, well away from the edges that move them.
   always @(negedge mclk) begin
      while (exp_q.size() > 0) begin
         prs_note_s n;
         n = exp_q.pop_front();
         check(obs(n.sel), n.exp);
      end
   end
   task automatic note(input logic [2:0] sel, input logic [31:0] exp);
      exp_q.push_back({sel, exp});
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #10;
   endtask
   // Bounded wait for a state; running out shows as a mismatch.
   task automatic wait_st(input prs_state_e s, input int lim);
      int k;
      k = 0;
      while (sequencer_state !== s && k < lim) begin
         step(1);
         k++;
      end
      note(3'h1, 32'(s));
   endtask
   task automatic complete_run();
      step(2);
      if (fails == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Guard against a hang well above the expected run length.
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 90000) begin
         fails++;
         complete_run();
      end
   end
   initial begin
      void'($urandom(32'hc1fd));
      rst_n = 0;
      precharge = 6'h04;
      fault_cmd = 6'h00;
      pin_drv = '0;
      pin_drv.above_undervoltage_lockout = 1;
      pin_drv.above_monitor = 1;
      pin_drv.sleep_request_a = 1;
      pin_drv.sleep_request_b = 1;
      pin_drv.buck_pair_enable_input = 1;
      pin_drv.below_recover_temp = 1;
      pin_drv.sequence_strap_pin = STRAP_HIZ;
      cfg = '0;
      cfg.rail_slot = {5'h01, 5'h01, 5'h00, 5'h01, 5'h02, 5'h01};
      cfg.rail_extra_enable_delay[5] = 4'h1;
      cfg.rail_sleep_shutdown_delay[4] = 4'h1;
      cfg.rail_resume_delay[4] = 3'h1;
      cfg.rail_soft_start_select = 12'($urandom);
      cfg.keep_in_sleep_a = 6'h05;
      cfg.keep_in_sleep_b = 6'h05;
      cfg.sleep_voltage_switch_enable = 2'h2;
      cfg.buck_b_normal_voltage = 8'($urandom);
      cfg.buck_b_sleep_voltage = ~cfg.buck_b_normal_voltage;
      cfg.buck_c_normal_voltage = 8'($urandom);
      cfg.buck_c_sleep_voltage = ~cfg.buck_c_normal_voltage;
      step(8);
      rst_n = 1;
      // Residual charge holds off power-up until it bleeds away.
      step(5000);
      note(3'h1, 32'(ST_STANDBY));
      precharge = 6'h00;
      wait_st(ST_POWERUP, 5000);
      step(10);
      note(3'h0, 32'h15);
      step(TICK_CYC - 30);
      note(3'h0, 32'h15);
      step(40);
      note(3'h0, 32'h37);
      wait_st(ST_NORMAL, 100);
      note(3'h2, 32'h1);
      cfg.residual_guard_mask = 1;
      // Sleep from source a: rail 4 waits its shutdown delay.
      pin_drv.sleep_request_a = 0;
      step(10);
      note(3'h0, 32'h15);
      step(TICK_CYC + 20);
      note(3'h1, 32'(ST_SLEEP));
      note(3'h5, 32'h05);
      note(3'h3, 32'(cfg.buck_b_normal_voltage));
      pin_drv.sleep_request_b = 0;
      step(10);
      note(3'h3, 32'(cfg.buck_b_sleep_voltage));
      note(3'h4, 32'(cfg.buck_c_sleep_voltage));
      pin_drv.sleep_request_a = 1;
      pin_drv.sleep_request_b = 1;
      step(20);
      note(3'h0, 32'h07);
      note(3'h2, 32'h1);
      step(TICK_CYC + 10);
      note(3'h0, 32'h37);
      wait_st(ST_NORMAL, 100);
      // Pair input dropped and raised again in normal.
      pin_drv.buck_pair_enable_input = 0;
      step(10);
      note(3'h0, 32'h34);
      pin_drv.buck_pair_enable_input = 1;
      step(5);
      note(3'h0, 32'h34);
      step(25);
      note(3'h0, 32'h37);
      wait_st(ST_NORMAL, 100);
      // A rail fault that outlives the first retry.
      fault_cmd = 6'h04;
      step(10);
      note(3'h1, 32'(ST_RECOVER));
      note(3'h7, 32'({cfg.rail_soft_start_select & 12'hf3f, 6'h04}));
      note(3'h6, 32'h3b);
      step(RETRY * 2 + 20);
      note(3'h1, 32'(ST_RECOVER));
      fault_cmd = 6'h00;
      wait_st(ST_NORMAL, 9000);
      // Over-temperature, then cooling in two steps.
      pin_drv.over_temp = 1;
      pin_drv.below_recover_temp = 0;
      step(10);
      note(3'h1, 32'(ST_THERMAL));
      note(3'h0, 32'h0);
      pin_drv.over_temp = 0;
      step(20);
      note(3'h1, 32'(ST_THERMAL));
      pin_drv.below_recover_temp = 1;
      wait_st(ST_NORMAL, 9000);
      // Disable and lockout drop every rail at once.
      pin_drv.power_disable_input = 1;
      step(10);
      note(3'h6, 32'h3f);
      pin_drv.power_disable_input = 0;
      wait_st(ST_NORMAL, 9000);
      pin_drv.above_undervoltage_lockout = 0;
      step(10);
      note(3'h1, 32'(ST_OFF));
      note(3'h0, 32'h0);
      // Strap low delays buck 3 by one tick.
      pin_drv.sequence_strap_pin = STRAP_LOW;
      pin_drv.above_undervoltage_lockout = 1;
      wait_st(ST_POWERUP, 5000);
      step(10);
      note(3'h0, 32'h01);
      wait_st(ST_NORMAL, 20000);
      complete_run();
   end
endmodule
